/* rtl/pwl_defs.vh */
`ifndef PWL_DEFS_VH
`define PWL_DEFS_VH
// register offsets
`define PWL_REG_LOCK_MODE 4'h0
`define PWL_REG_DR_PW_SET 4'h1
`define PWL_REG_DR_PW_AUTH 4'h2
`define PWL_REG_LM_PW_SET 4'h3
`define PWL_REG_LM_PW_AUTH 4'h4
`define PWL_REG_PUD_SEL 4'h5
`define PWL_REG_AUTO_RET 4'h6
`define PWL_REG_UPAR_AUTO 4'h7
`define PWL_REG_DISP_RESTRICT 4'h8
`define PWL_REG_STATUS 4'h9
`define PWL_REG_TERM_FUNC0 4'ha
// lock modes
`define PWL_LOCK_TERM 16'h0000
`define PWL_LOCK_TERM_FREQ 16'h0001
`define PWL_LOCK_ALWAYS 16'h0002
`define PWL_LOCK_ALWAYS_FREQ 16'h0003
`define PWL_TERM_FUNC_LOCK 8'h0f
// password and display codes
`define PWL_PW_NONE 16'h0000
`define PWL_PUD_LAST 16'h0000
`define PWL_PUD_MON_MAX 16'h003c
`define PWL_PUD_FREQ 16'h00c9
`define PWL_PUD_MODE_B 16'h00ca
`define PWL_PUD_RESET 16'h0001
`define PWL_EN_ON 16'h0001
`define PWL_EN_OFF 16'h0000
// display classes
`define PWL_DISP_LAST 2'h0
`define PWL_DISP_MON 2'h1
`define PWL_DISP_FREQ 2'h2
`define PWL_DISP_SELF 2'h3
// idle time
`define PWL_IDLE_MIN 10
`define PWL_CLK_MHZ 100
`endif

/* rtl/pwl_param_lock.v */
`timescale 1ns/100ps
`include "pwl_defs.vh"
module pwl_param_lock #(
	parameter NTERM = 7,
	parameter NSLOT = 32,
	parameter [39:0] IDLE_CYCLES = `PWL_IDLE_MIN * 40'd60 * `PWL_CLK_MHZ * 40'd1000000
) (
	input wire mclk,
	input wire rst_b,
	input wire clkEn,
	input wire [3:0] regAddr,
	input wire [15:0] regWrData,
	input wire regWrStb,
	input wire regRdStb,
	output reg [15:0] regRdData,
	input wire [NTERM-1:0] termPins,
	input wire keyPress,
	input wire paramWrReq,
	input wire paramIsFreq,
	input wire paramIsInit,
	input wire batchWrReq,
	input wire batchRdReq,
	output reg paramWrOk,
	output reg batchWrOk,
	output reg batchRdOk,
	output reg authGood,
	output reg authErr,
	output reg autoReturn,
	output reg [1:0] dispClass,
	output reg [5:0] dispMonitor,
	output reg modeBSel,
	output reg userSlotClear
);
	reg [NTERM-1:0] termMeta;
	reg [NTERM-1:0] termSync;
	reg [8*NTERM-1:0] termFunc;
	reg [15:0] lockMode;
	reg [15:0] dispRestrict;
	reg [15:0] pwA;
	reg [15:0] pwB;
	reg unlockA;
	reg unlockB;
	reg [15:0] pudSel;
	reg [15:0] autoRet;
	reg [15:0] upAuto;
	reg otherChanged;
	reg [39:0] idleCnt;
	reg [39:0] next_idleCnt;
	reg writeLockInput;
	reg lockActive;
	reg freqAllowed;
	reg guardA;
	reg guardB;
	reg idleExpire;
	reg idleRelock;
	reg [15:0] next_regRdData;
	reg [1:0] next_dispClass;
	integer i;

	// one function decides whether a password gates its guarded setting
	function locked;
		input [15:0] pw;
		input unl;
		begin
			locked = (pw != `PWL_PW_NONE) && !unl;
		end
	endfunction

	// auth against an empty password always fails, so 0000 never unlocks
	function authOk;
		input [15:0] pw;
		input [15:0] d;
		begin
			authOk = (pw != `PWL_PW_NONE) && (d == pw);
		end
	endfunction

	// terminal function registers form one run of addresses after the status word
	function isTermAddr;
		input [3:0] a;
		begin
			isTermAddr = (a >= `PWL_REG_TERM_FUNC0) && (a < `PWL_REG_TERM_FUNC0 + NTERM);
		end
	endfunction

	function [7:0] termOf;
		input [3:0] a;
		input [8*NTERM-1:0] f;
		reg [3:0] k;
		begin
			k = a - `PWL_REG_TERM_FUNC0;
			termOf = f[8*k +: 8];
		end
	endfunction

	always @* begin
		writeLockInput = 1'b0;
		for (i = 0; i < NTERM; i = i + 1) begin
			if (termFunc[8*i +: 8] == `PWL_TERM_FUNC_LOCK && termSync[i]) begin
				writeLockInput = 1'b1;
			end
		end
	end

	always @* begin
		lockActive = 1'b0;
		freqAllowed = 1'b0;
		case (lockMode)
			`PWL_LOCK_TERM: begin
				lockActive = writeLockInput;
			end
			`PWL_LOCK_TERM_FREQ: begin
				lockActive = writeLockInput;
				freqAllowed = 1'b1;
			end
			`PWL_LOCK_ALWAYS: begin
				lockActive = 1'b1;
			end
			`PWL_LOCK_ALWAYS_FREQ: begin
				lockActive = 1'b1;
				freqAllowed = 1'b1;
			end
			default: begin
				lockActive = 1'b0;
			end
		endcase
	end

	// the lock mode itself must stay writable or a lock could never be lifted
	wire genWrOk = !lockActive;

	always @* begin
		guardA = locked(pwA, unlockA);
		guardB = locked(pwB, unlockB);
		idleExpire = (idleCnt == IDLE_CYCLES - 40'h1);
		// a key pressed in the expiring cycle wins, so the operator is never cut off
		idleRelock = idleExpire && !keyPress;
	end

	always @* begin
		if (keyPress) begin
			next_idleCnt = 40'h0;
		end else if (idleExpire) begin
			next_idleCnt = 40'h0;
		end else begin
			next_idleCnt = idleCnt + 40'h1;
		end
	end

	// two flops ahead of any logic: the terminals are asynchronous to mclk
	always @(posedge mclk) begin
		if (!rst_b) begin
			termMeta <= {NTERM{1'b0}};
			termSync <= {NTERM{1'b0}};
		end else if (clkEn) begin
			termMeta <= termPins;
			termSync <= termMeta;
		end
	end

	always @(posedge mclk) begin
		if (!rst_b) begin
			idleCnt <= 40'h0;
		end else if (clkEn) begin
			idleCnt <= next_idleCnt;
		end
	end

	// passwords and their unlock flags; every relock path lives here
	always @(posedge mclk) begin
		if (!rst_b) begin
			pwA <= `PWL_PW_NONE;
			pwB <= `PWL_PW_NONE;
			unlockA <= 1'b0;
			unlockB <= 1'b0;
			authGood <= 1'b0;
			authErr <= 1'b0;
		end else if (clkEn) begin
			authGood <= 1'b0;
			authErr <= 1'b0;
			if (idleRelock) begin
				unlockA <= 1'b0;
				unlockB <= 1'b0;
			end
			if (regWrStb) begin
				case (regAddr)
					`PWL_REG_DR_PW_SET: begin
						if (!guardA) begin
							pwA <= regWrData;
							unlockA <= 1'b0;
						end
					end
					`PWL_REG_LM_PW_SET: begin
						if (!guardB) begin
							pwB <= regWrData;
							unlockB <= 1'b0;
						end
					end
					`PWL_REG_DR_PW_AUTH: begin
						if (authOk(pwA, regWrData)) begin
							unlockA <= 1'b1;
							authGood <= 1'b1;
						end else begin
							authErr <= 1'b1;
						end
					end
					`PWL_REG_LM_PW_AUTH: begin
						if (authOk(pwB, regWrData)) begin
							unlockB <= 1'b1;
							authGood <= 1'b1;
						end else begin
							authErr <= 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// settings; a guarded setting ignores writes silently instead of flagging them
	always @(posedge mclk) begin
		if (!rst_b) begin
			termFunc <= {8*NTERM{1'b0}};
			lockMode <= `PWL_LOCK_TERM;
			dispRestrict <= 16'h0000;
			pudSel <= `PWL_PUD_RESET;
			autoRet <= `PWL_EN_OFF;
			upAuto <= `PWL_EN_OFF;
			otherChanged <= 1'b0;
			userSlotClear <= 1'b0;
		end else if (clkEn) begin
			userSlotClear <= 1'b0;
			if (paramWrReq) begin
				otherChanged <= 1'b1;
			end
			if (regWrStb) begin
				case (regAddr)
					`PWL_REG_LOCK_MODE: begin
						if (!guardB) begin
							lockMode <= regWrData;
						end
					end
					`PWL_REG_DISP_RESTRICT: begin
						if (!guardA) begin
							dispRestrict <= regWrData;
						end
					end
					`PWL_REG_DR_PW_SET: begin
						if (!guardA && regWrData == `PWL_PW_NONE) begin
							dispRestrict <= 16'h0000;
						end
					end
					`PWL_REG_LM_PW_SET: begin
						if (!guardB && regWrData == `PWL_PW_NONE) begin
							lockMode <= `PWL_LOCK_TERM;
						end
					end
					`PWL_REG_PUD_SEL: begin
						pudSel <= regWrData;
						// a store write in the same cycle still counts as another change
						otherChanged <= paramWrReq;
					end
					`PWL_REG_AUTO_RET: begin
						autoRet <= regWrData;
					end
					`PWL_REG_UPAR_AUTO: begin
						upAuto <= regWrData;
						if (upAuto == `PWL_EN_OFF && regWrData == `PWL_EN_ON) begin
							userSlotClear <= 1'b1;
						end
					end
					default: begin
						if (isTermAddr(regAddr)) begin
							termFunc[8*(regAddr - `PWL_REG_TERM_FUNC0) +: 8] <= regWrData[7:0];
						end
					end
				endcase
			end
		end
	end

	// store and batch handshakes answer exactly one cycle after the request
	always @(posedge mclk) begin
		if (!rst_b) begin
			paramWrOk <= 1'b0;
			batchWrOk <= 1'b0;
			batchRdOk <= 1'b0;
			autoReturn <= 1'b0;
		end else if (clkEn) begin
			paramWrOk <= paramWrReq && (freqAllowed && paramIsFreq || genWrOk)
				&& !(paramIsInit && (lockActive || dispRestrict != 16'h0000));
			batchWrOk <= batchWrReq && !lockActive;
			batchRdOk <= batchRdReq;
			autoReturn <= idleRelock && autoRet == `PWL_EN_ON;
		end
	end

	// display selection is decoded continuously from the stored code
	always @* begin
		if (pudSel == `PWL_PUD_FREQ) begin
			next_dispClass = `PWL_DISP_FREQ;
		end else if (pudSel >= 16'h0001 && pudSel <= `PWL_PUD_MON_MAX) begin
			next_dispClass = `PWL_DISP_MON;
		end else if ((pudSel == `PWL_PUD_LAST || pudSel == `PWL_PUD_MODE_B)
			&& !otherChanged) begin
			next_dispClass = `PWL_DISP_SELF;
		end else begin
			next_dispClass = `PWL_DISP_LAST;
		end
	end

	always @(posedge mclk) begin
		if (!rst_b) begin
			dispClass <= `PWL_DISP_MON;
			dispMonitor <= 6'h01;
			modeBSel <= 1'b0;
		end else if (clkEn) begin
			dispClass <= next_dispClass;
			dispMonitor <= pudSel[5:0];
			modeBSel <= (pudSel == `PWL_PUD_MODE_B);
		end
	end

	// reads answer zero outside the cycle after the strobe, so stale words never linger
	always @* begin
		next_regRdData = 16'h0000;
		if (regRdStb) begin
			case (regAddr)
				`PWL_REG_LOCK_MODE: next_regRdData = lockMode;
				`PWL_REG_DISP_RESTRICT: next_regRdData = dispRestrict;
				`PWL_REG_DR_PW_SET: next_regRdData = guardA ? 16'h0000 : pwA;
				`PWL_REG_LM_PW_SET: next_regRdData = guardB ? 16'h0000 : pwB;
				`PWL_REG_PUD_SEL: next_regRdData = pudSel;
				`PWL_REG_AUTO_RET: next_regRdData = autoRet;
				`PWL_REG_UPAR_AUTO: next_regRdData = upAuto;
				`PWL_REG_STATUS: next_regRdData = {11'h000, writeLockInput, lockActive,
					freqAllowed, guardB, guardA};
				default: begin
					if (isTermAddr(regAddr)) begin
						next_regRdData = {8'h00, termOf(regAddr, termFunc)};
					end
				end
			endcase
		end
	end

	always @(posedge mclk) begin
		if (!rst_b) begin
			regRdData <= 16'h0000;
		end else if (clkEn) begin
			regRdData <= next_regRdData;
		end
	end
endmodule

/* verification/pwl_param_lock_assertions.sv */
`timescale 1ns/100ps
module pwl_param_lock_assertions (
	input wire mclk,
	input wire rst_b,
	input wire [3:0] regAddr,
	input wire [15:0] regWrData,
	input wire regWrStb,
	input wire paramWrReq,
	input wire batchWrReq,
	input wire batchRdReq,
	input wire paramWrOk,
	input wire batchWrOk,
	input wire batchRdOk,
	input wire authGood,
	input wire authErr,
	input wire [1:0] dispClass,
	input wire [5:0] dispMonitor,
	input wire userSlotClear
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_auth_cause: assert property ((authGood || authErr) |->
		$past(regWrStb) && ($past(regAddr) == 4'h2 || $past(regAddr) == 4'h4))
		else $error("auth verdict without auth write");
	a_auth_answer: assert property (regWrStb && regAddr == 4'h4 |=> authGood ^ authErr)
		else $error("auth write without one verdict");
	a_batch_read: assert property (batchRdReq |=> batchRdOk)
		else $error("batch read refused");
	a_batch_cause: assert property (batchWrOk |-> $past(batchWrReq))
		else $error("batch write grant without request");
	a_write_cause: assert property (paramWrOk |-> $past(paramWrReq))
		else $error("write grant without request");
	a_mon_range: assert property (dispClass == 2'h1 |-> dispMonitor inside {[1:60]})
		else $error("monitor number out of range");
	a_slot_cause: assert property (userSlotClear |->
		$past(regWrStb && regAddr == 4'h7 && regWrData == 16'h0001))
		else $error("slot clear without enable write");
	a_reset_disp: assert property ($rose(rst_b) |-> dispClass == 2'h1 && dispMonitor == 6'h01)
		else $error("display not at default after reset");
	c_auth: cover property (authGood);
	c_slot: cover property (userSlotClear);
	c_batch: cover property (batchWrOk);
endmodule
bind pwl_param_lock pwl_param_lock_assertions u_pwl_param_lock_assertions (.*);

/* verification/pwl_keypad_model.sv */
`timescale 1ns/100ps
module pwl_keypad_model (
	input wire mclk,
	input wire lockOn,
	input wire press,
	output reg [6:0] termPins,
	output reg keyPress
);
	reg lastPress = 1'b0;
	initial termPins = 7'h00;
	initial keyPress = 1'b0;
	// only terminal 0 carries the lock function; the others idle inactive
	always @(posedge mclk) begin
		termPins <= {6'h00, lockOn};
		keyPress <= press && !lastPress;
		lastPress <= press;
	end
endmodule

/* verification/tb.sv */
`timescale 1ns/100ps
module tb;
	reg mclk = 0, rst_b = 0, regWrStb = 0, regRdStb = 0, lockOn = 0, press = 0;
	reg paramWrReq = 0, paramIsFreq = 0, paramIsInit = 0, batchWrReq = 0, batchRdReq = 0;
	reg [3:0] regAddr = 4'h0;
	reg [15:0] regWrData = 16'h0000;
	wire clkEn = 1'b1;
	wire [15:0] regRdData;
	wire [6:0] termPins;
	wire [1:0] dispClass;
	wire [5:0] dispMonitor;
	wire keyPress, paramWrOk, batchWrOk, batchRdOk, authGood, authErr, autoReturn;
	wire modeBSel, userSlotClear;
	integer nFail = 0, checks = 0, m, t, nA, nU;
	always #5 mclk = ~mclk;
	pwl_keypad_model u_pwl_keypad_model (.mclk(mclk), .lockOn(lockOn), .press(press),
		.termPins(termPins), .keyPress(keyPress));
	// short idle count keeps the ten-minute timers inside the run
	pwl_param_lock #(.IDLE_CYCLES(40'd50)) u_pwl_param_lock (.mclk(mclk), .rst_b(rst_b),
		.clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
		.regRdStb(regRdStb), .regRdData(regRdData), .termPins(termPins), .keyPress(keyPress),
		.paramWrReq(paramWrReq), .paramIsFreq(paramIsFreq), .paramIsInit(paramIsInit),
		.batchWrReq(batchWrReq), .batchRdReq(batchRdReq), .paramWrOk(paramWrOk),
		.batchWrOk(batchWrOk), .batchRdOk(batchRdOk), .authGood(authGood), .authErr(authErr),
		.autoReturn(autoReturn), .dispClass(dispClass), .dispMonitor(dispMonitor),
		.modeBSel(modeBSel), .userSlotClear(userSlotClear));
	task chk(input [63:0] nm, input [15:0] seen, input [15:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			nFail = nFail + 1;
			$display("wrong value %0s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input [3:0] a, input [15:0] d);
		@(posedge mclk);
		regWrStb <= 1;
		regAddr <= a;
		regWrData <= d;
		@(posedge mclk);
		regWrStb <= 0;
	endtask
	task rd(input [3:0] a, input [15:0] e);
		@(posedge mclk);
		regRdStb <= 1;
		regAddr <= a;
		@(posedge mclk);
		regRdStb <= 0;
		#1 chk("rd", regRdData, e);
	endtask
	task au(input [3:0] a, input [15:0] d, input g);
		wr(a, d);
		#1 chk("good", authGood, g);
		chk("err", authErr, !g);
	endtask
	task pw(input f, input n, input e);
		@(posedge mclk);
		paramWrReq <= 1;
		paramIsFreq <= f;
		paramIsInit <= n;
		@(posedge mclk);
		paramWrReq <= 0;
		#1 chk("wrOk", paramWrOk, e);
	endtask
	task bt(input e);
		@(posedge mclk);
		batchWrReq <= 1;
		@(posedge mclk);
		batchWrReq <= 0;
		batchRdReq <= 1;
		#1 chk("bWr", batchWrOk, e);
		@(posedge mclk);
		batchRdReq <= 0;
		#1 chk("bRd", batchRdOk, 1);
	endtask
	task watch(input integer n);
		nA = 0;
		nU = 0;
		repeat (n) begin
			#1 nA = nA + autoReturn;
			nU = nU + userSlotClear;
			@(posedge mclk);
		end
	endtask
	task disp(input [15:0] c, input [1:0] e);
		wr(4'h5, c);
		repeat (2) @(posedge mclk);
		#1 chk("class", dispClass, e);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checks, nFail);
		if (nFail == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#900000 nFail = nFail + 1;
		give_verdict;
	end
	initial begin
		repeat (10) @(posedge mclk);
		rst_b <= 1;
		rd(4'h5, 16'h0001);
		wr(4'ha, 16'h000f);
		for (m = 0; m < 4; m = m + 1)
			for (t = 0; t < 2; t = t + 1) begin
				lockOn <= t[0];
				wr(4'h0, m[15:0]);
				rd(4'h0, m[15:0]);
				pw(0, 0, m < 2 && !t);
				pw(1, 0, m[0] || (m < 2 && !t));
				pw(0, 1, m < 2 && !t);
				bt(m < 2 && !t);
			end
		$display("test lock modes done");
		lockOn <= 0;
		wr(4'h0, 16'h0000);
		au(4'h4, 16'h0000, 0);
		wr(4'h3, 16'h1234);
		rd(4'h3, 16'h0000);
		wr(4'h0, 16'h0002);
		rd(4'h0, 16'h0000);
		au(4'h4, 16'h1235, 0);
		au(4'h4, 16'h1234, 1);
		wr(4'h0, 16'h0002);
		rd(4'h0, 16'h0002);
		wr(4'h3, 16'h0000);
		rd(4'h0, 16'h0000);
		wr(4'h1, 16'h00ab);
		wr(4'h8, 16'h0001);
		rd(4'h8, 16'h0000);
		au(4'h2, 16'h00ab, 1);
		wr(4'h8, 16'h0001);
		rd(4'h8, 16'h0001);
		wr(4'h1, 16'h0000);
		rd(4'h8, 16'h0000);
		$display("test passwords done");
		wr(4'h6, 16'h0001);
		wr(4'h3, 16'h0055);
		au(4'h4, 16'h0055, 1);
		press <= 1;
		repeat (2) @(posedge mclk);
		watch(42);
		chk("autoRet", nA, 0);
		watch(20);
		chk("autoRet", nA, 1);
		press <= 0;
		wr(4'h0, 16'h0001);
		rd(4'h0, 16'h0000);
		$display("test idle done");
		disp(16'h0000, 2'h3);
		pw(0, 0, 1);
		repeat (2) @(posedge mclk);
		#1 chk("class", dispClass, 0);
		disp(16'h003c, 2'h1);
		chk("mon", dispMonitor, 16'h003c);
		disp(16'h00c9, 2'h2);
		disp(16'h00ca, 2'h3);
		chk("modeB", modeBSel, 1);
		$display("test display done");
		wr(4'h7, 16'h0000);
		wr(4'h7, 16'h0001);
		watch(3);
		chk("slotClr", nU, 1);
		wr(4'h7, 16'h0001);
		watch(3);
		chk("slotClr", nU, 0);
		$display("test user slots done");
		give_verdict;
	end
endmodule
